// >>> rtl/fcp_pkg.sv
// Purpose: Shared constants for the four-channel PWM unit
// Assumes: 8-bit special function register port, 50 MHz oscillator clock
// Notes:   Offsets are the direct SFR addresses of the unit
package fcp_pkg;
    localparam int          NUM_CH        = 4;
    localparam int          CNT_W         = 10;
    // Register addresses
    localparam logic [7:0]  ADDR_CTRL     = 8'hB5;
    localparam logic [7:0]  ADDR_D0H      = 8'hBC;
    localparam logic [7:0]  ADDR_D0L      = 8'hBD;
    localparam logic [7:0]  ADDR_D1H      = 8'hBE;
    localparam logic [7:0]  ADDR_D1L      = 8'hBF;
    localparam logic [7:0]  ADDR_D2H      = 8'hB1;
    localparam logic [7:0]  ADDR_D2L      = 8'hB2;
    localparam logic [7:0]  ADDR_D3H      = 8'hB3;
    localparam logic [7:0]  ADDR_D3L      = 8'hB4;
    localparam logic [7:0]  ADDR_MAXH     = 8'hCE;
    localparam logic [7:0]  ADDR_MAXL     = 8'hCF;
    // Field positions
    localparam int          CS_LSB        = 5;
    localparam int          IDLE_BIT      = 7;
    // Reset values
    localparam logic [7:0]  RST_CTRL      = 8'h00;
    localparam logic [9:0]  RST_DUTY      = 10'h000;
    localparam logic [9:0]  RST_MAX       = 10'h0FF;
    // Clock select codes
    localparam logic [2:0]  CS_DIV1       = 3'h0;
    localparam logic [2:0]  CS_DIV2       = 3'h1;
    localparam logic [2:0]  CS_DIV4       = 3'h2;
    localparam logic [2:0]  CS_DIV6       = 3'h3;
    localparam logic [2:0]  CS_DIV8       = 3'h4;
    localparam logic [2:0]  CS_DIV12      = 3'h5;
    localparam logic [2:0]  CS_T0_OVF     = 3'h6;
    localparam logic [2:0]  CS_T0_PIN     = 3'h7;
    localparam logic [3:0]  PRESC_LAST    = 4'hB;
    localparam logic [1:0]  DIV4_LAST     = 2'h3;
    localparam logic [3:0]  DIV6_MID      = 4'h5;
    localparam logic [2:0]  DIV8_LAST     = 3'h7;
endpackage

// >>> rtl/fcp_pwm.sv
// Purpose: Four-channel PWM unit with shared 10-bit counter
// Assumes: SFR port with one-cycle write and combinational read
// Notes:   Changing the count clock select does not restart the prescalers
`timescale 1ns/100ps
module fcp_pwm (
    input  wire logic        clk_i,               // Oscillator clock, 50 MHz
    input  wire logic        nrst_i,              // Async reset, active low
    input  wire logic [7:0]  sfr_addr_i,          // SFR address
    input  wire logic        sfr_wr_i,            // SFR write strobe
    input  wire logic [7:0]  sfr_wdata_i,         // SFR write data
    output logic      [7:0]  sfr_rdata_o,         // SFR read data
    output logic             sfr_hit_o,           // Address belongs to unit
    input  wire logic        t0_overflow_i,       // Timer 0 overflow pulse
    input  wire logic        timer0_ext_input_i,  // Timer 0 external pin
    input  wire logic        irq_flag_clr_i,      // Software flag clear
    output logic             modulator_irq_flag_o, // Shared interrupt flag
    output logic      [3:0]  pwm_o                // Channel outputs
);
    typedef struct packed {
        logic [2:0]                    count_clock_select;
        logic [3:0]                    enable;
        logic [3:0]                    idle_level;
        logic [3:0][9:0]               duty;
        logic [9:0]                    period_max_value;
        logic [9:0]                    count;
        logic                          irq_flag;
        logic [3:0]                    out;
    } fcp_state_t;

    fcp_state_t  st, next_st;
    fcp_tick_if  tk ();
    logic        ovf;

    // Channel index of a duty register address, bit 0 says low byte
    function automatic logic [2:0] duty_slot(input logic [7:0] a);
        unique case (a)
            fcp_pkg::ADDR_D0H: duty_slot = 3'h0;
            fcp_pkg::ADDR_D1H: duty_slot = 3'h2;
            fcp_pkg::ADDR_D2H: duty_slot = 3'h4;
            fcp_pkg::ADDR_D3H: duty_slot = 3'h6;
            fcp_pkg::ADDR_D0L: duty_slot = 3'h1;
            fcp_pkg::ADDR_D1L: duty_slot = 3'h3;
            fcp_pkg::ADDR_D2L: duty_slot = 3'h5;
            fcp_pkg::ADDR_D3L: duty_slot = 3'h7;
            default:           duty_slot = 3'h0;
        endcase
    endfunction

    function automatic logic is_duty(input logic [7:0] a);
        is_duty = (a == fcp_pkg::ADDR_D0H) || (a == fcp_pkg::ADDR_D0L) ||
                  (a == fcp_pkg::ADDR_D1H) || (a == fcp_pkg::ADDR_D1L) ||
                  (a == fcp_pkg::ADDR_D2H) || (a == fcp_pkg::ADDR_D2L) ||
                  (a == fcp_pkg::ADDR_D3H) || (a == fcp_pkg::ADDR_D3L);
    endfunction

    assign tk.sel = st.count_clock_select;

    // Count clock enable generator
    fcp_tick_gen u_tick (
        .clk_i              (clk_i),
        .nrst_i             (nrst_i),
        .t0_overflow_i      (t0_overflow_i),
        .timer0_ext_input_i (timer0_ext_input_i),
        .tk                 (tk)
    );

    assign ovf = tk.tick && (st.count >= st.period_max_value);

    // Register writes, counter, flag and output levels
    always_comb begin
        logic [2:0] slot;
        slot    = duty_slot(sfr_addr_i);
        next_st = st;
        if (sfr_wr_i) begin
            if (sfr_addr_i == fcp_pkg::ADDR_CTRL) begin
                next_st.count_clock_select = sfr_wdata_i[fcp_pkg::CS_LSB +: 3];
                next_st.enable             = sfr_wdata_i[3:0];
            end
            if (sfr_addr_i == fcp_pkg::ADDR_MAXH) begin
                next_st.period_max_value[9:8] = sfr_wdata_i[1:0];
            end
            if (sfr_addr_i == fcp_pkg::ADDR_MAXL) begin
                next_st.period_max_value[7:0] = sfr_wdata_i;
            end
            if (is_duty(sfr_addr_i)) begin
                if (slot[0]) begin
                    next_st.duty[slot[2:1]][7:0] = sfr_wdata_i;
                end else begin
                    next_st.duty[slot[2:1]][9:8]     = sfr_wdata_i[1:0];
                    next_st.idle_level[slot[2:1]]    = sfr_wdata_i[fcp_pkg::IDLE_BIT];
                end
            end
        end
        // Shared counter
        if (ovf) begin
            next_st.count = '0;
        end else if (tk.tick) begin
            next_st.count = st.count + 10'h001;
        end
        // Flag: set wins over software clear
        if (ovf) begin
            next_st.irq_flag = 1'b1;
        end else if (irq_flag_clr_i) begin
            next_st.irq_flag = 1'b0;
        end
        // Outputs: active while enabled and count below duty, idle otherwise
        for (int i = 0; i < fcp_pkg::NUM_CH; i++) begin
            if (st.enable[i] && (next_st.count < st.duty[i])) begin
                next_st.out[i] = ~next_st.idle_level[i];
            end else begin
                next_st.out[i] = next_st.idle_level[i];
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st                    <= '0;
            st.count_clock_select <= fcp_pkg::RST_CTRL[fcp_pkg::CS_LSB +: 3];
            st.duty               <= {fcp_pkg::NUM_CH{fcp_pkg::RST_DUTY}};
            st.period_max_value   <= fcp_pkg::RST_MAX;
        end else begin
            st <= next_st;
        end
    end

    // Register read
    always_comb begin
        logic [2:0] rs;
        rs          = duty_slot(sfr_addr_i);
        sfr_hit_o   = 1'b1;
        sfr_rdata_o = 8'h00;
        if (sfr_addr_i == fcp_pkg::ADDR_CTRL) begin
            sfr_rdata_o = {st.count_clock_select, 1'b0, st.enable};
        end else if (sfr_addr_i == fcp_pkg::ADDR_MAXH) begin
            sfr_rdata_o = {6'h00, st.period_max_value[9:8]};
        end else if (sfr_addr_i == fcp_pkg::ADDR_MAXL) begin
            sfr_rdata_o = st.period_max_value[7:0];
        end else if (is_duty(sfr_addr_i)) begin
            sfr_rdata_o = rs[0] ? st.duty[rs[2:1]][7:0]
                                : {st.idle_level[rs[2:1]], 5'h00, st.duty[rs[2:1]][9:8]};
        end else begin
            sfr_hit_o = 1'b0;
        end
    end

    assign modulator_irq_flag_o = st.irq_flag;
    assign pwm_o                = st.out;
endmodule

// >>> rtl/fcp_tick_gen.sv
// Purpose: Produce the PWM count enable from the selected source
// Assumes: timer0_ext_input is asynchronous, others are synchronous
// Notes:   External input counts on its falling edge after two flops
`timescale 1ns/100ps
module fcp_tick_gen (
    input  wire logic   clk_i,             // Oscillator clock
    input  wire logic   nrst_i,            // Async reset, active low
    input  wire logic   t0_overflow_i,     // Timer 0 overflow pulse
    input  wire logic   timer0_ext_input_i, // Timer 0 external pin
    fcp_tick_if.src     tk                 // Select in, tick out
);
    typedef struct packed {
        logic [3:0] presc;
        logic [2:0] presc8;
        logic       sync1;
        logic       sync2;
        logic       pin_d;
    } fcp_tick_state_t;

    fcp_tick_state_t st, next_st;

    // Prescaler, pin synchroniser and pin edge history
    always_comb begin
        next_st       = st;
        next_st.presc = (st.presc == fcp_pkg::PRESC_LAST) ? 4'h0 : st.presc + 4'h1;
        // Eight does not divide twelve, so divide by 8 has its own wrap-around count
        next_st.presc8 = st.presc8 + 3'h1;
        next_st.sync1 = timer0_ext_input_i;
        next_st.sync2 = st.sync1;
        next_st.pin_d = st.sync2;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Source multiplexer
    always_comb begin
        unique case (tk.sel)
            fcp_pkg::CS_DIV1:   tk.tick = 1'b1;
            fcp_pkg::CS_DIV2:   tk.tick = (st.presc[0] == 1'b1);
            fcp_pkg::CS_DIV4:   tk.tick = (st.presc[1:0] == fcp_pkg::DIV4_LAST);
            fcp_pkg::CS_DIV6:   tk.tick = (st.presc == fcp_pkg::DIV6_MID) || (st.presc == fcp_pkg::PRESC_LAST);
            fcp_pkg::CS_DIV8:   tk.tick = (st.presc8 == fcp_pkg::DIV8_LAST);
            fcp_pkg::CS_DIV12:  tk.tick = (st.presc == fcp_pkg::PRESC_LAST);
            fcp_pkg::CS_T0_OVF: tk.tick = t0_overflow_i;
            fcp_pkg::CS_T0_PIN: tk.tick = st.pin_d & ~st.sync2;
        endcase
    end
endmodule

// >>> rtl/fcp_tick_if.sv
// Purpose: Count-clock select and tick between divider and core
// Assumes: Single clock domain
// Notes:   Divider drives tick, core reads it
`timescale 1ns/100ps
interface fcp_tick_if;
    logic [2:0] sel;   // Count clock select
    logic       tick;  // One-cycle count enable
    modport src (input sel, output tick);
    modport dst (output sel, input tick);
endinterface

// >>> sim/fcp_load_model.sv
// Purpose: Loads on the PWM pins, integrating high time per pin
// Assumes: Pins are driven push-pull by the unit
// Notes:   Counts restart while clr_i is high
`timescale 1ns/100ps
module fcp_load_model (
    input  wire logic        clk_i,  // Clock
    input  wire logic [3:0]  pin_i,  // PWM pins
    input  wire logic        clr_i,  // Clear counts
    output logic [3:0][7:0]  high_o  // High cycles per pin
);
    // Count sampled high cycles on every pin
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < 4; i++) begin
            high_o[i] <= clr_i ? 8'h00 : high_o[i] + {7'h00, pin_i[i]};
        end
    end
endmodule

// >>> sim/fcp_pwm_properties.sv
// Purpose: Port checks for the four-channel PWM unit
// Assumes: Bound to fcp_pwm, one clock domain
// Notes:   Shadows mirror enables, idle levels and nonzero duty halves
`timescale 1ns/100ps
module fcp_pwm_properties (
    input wire logic        clk_i,                // Clock
    input wire logic        nrst_i,               // Reset, active low
    input wire logic [7:0]  sfr_addr_i,           // Address
    input wire logic        sfr_wr_i,             // Write strobe
    input wire logic [7:0]  sfr_wdata_i,          // Write data
    input wire logic [7:0]  sfr_rdata_o,          // Read data
    input wire logic        sfr_hit_o,            // Decode hit
    input wire logic        t0_overflow_i,        // Timer 0 overflow
    input wire logic        timer0_ext_input_i,   // Timer 0 pin
    input wire logic        irq_flag_clr_i,       // Flag clear
    input wire logic        modulator_irq_flag_o, // Flag
    input wire logic [3:0]  pwm_o                 // Outputs
);
    localparam logic [7:0] ha [4] = '{8'hBC, 8'hBE, 8'hB1, 8'hB3};
    logic [3:0] en, idl, hz, lz;
    // Mirror register writes
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            {en, idl, hz, lz} <= '0;
        end else if (sfr_wr_i) begin
            if (sfr_addr_i == 8'hB5) en <= sfr_wdata_i[3:0];
            for (int i = 0; i < 4; i++) begin
                if (sfr_addr_i == ha[i]) {idl[i], hz[i]} <= {sfr_wdata_i[7], |sfr_wdata_i[1:0]};
                if (sfr_addr_i == ha[i] + 8'h01) lz[i] <= |sfr_wdata_i;
            end
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sequence wr_then(a);
        sfr_wr_i && sfr_addr_i == a ##1 sfr_addr_i == a;
    endsequence
    property rb(a, m);
        wr_then(a) |-> sfr_rdata_o == ($past(sfr_wdata_i) & m);
    endproperty
    hit_decode_a: assert property (sfr_hit_o == (sfr_addr_i inside {[8'hB1:8'hB5], [8'hBC:8'hBF], [8'hCE:8'hCF]}))
        else $error("address decode wrong");
    unmapped_zero_a: assert property (!sfr_hit_o |-> sfr_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    ctrl_readback_a: assert property (rb(8'hB5, 8'hEF))
        else $error("control readback wrong");
    duty_high_mask_a: assert property (rb(8'hBC, 8'h83))
        else $error("duty high readback wrong");
    max_high_mask_a: assert property (rb(8'hCE, 8'h03))
        else $error("maximum high readback wrong");
    flag_sticky_a: assert property (modulator_irq_flag_o && !irq_flag_clr_i |=> modulator_irq_flag_o)
        else $error("flag dropped without clear");
    // Idle level takes effect at its own write edge, enables and duty one edge later
    disabled_idle_a: assert property ((~$past(en) & (pwm_o ^ idl)) == 4'h0)
        else $error("disabled channel not idle");
    zero_duty_idle_a: assert property ((~$past(hz | lz) & (pwm_o ^ idl)) == 4'h0)
        else $error("zero duty channel not idle");
    period_start_a: assert property ($rose(modulator_irq_flag_o) |-> ((pwm_o ^ ~idl) & $past(en & (hz | lz))) == 4'h0)
        else $error("period start not active");
endmodule
bind fcp_pwm fcp_pwm_properties fcp_pwm_properties_inst (
    .clk_i(clk_i), .nrst_i(nrst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o), .t0_overflow_i(t0_overflow_i),
    .timer0_ext_input_i(timer0_ext_input_i), .irq_flag_clr_i(irq_flag_clr_i),
    .modulator_irq_flag_o(modulator_irq_flag_o), .pwm_o(pwm_o)
);

// >>> sim/fcp_pwm_tb_top.sv
// Purpose: Self-checking bench for the four-channel PWM unit
// Assumes: Register port with write strobe and combinational read
// Notes:   Timer 0 sources run free; the select picks one
`timescale 1ns/100ps
module fcp_pwm_tb_top;
    logic            clk_i = 1'b0;
    logic            nrst_i = 1'b0;
    logic            wr = 1'b0, clr = 1'b0, t0o = 1'b0, t0p = 1'b1, lc = 1'b1, hit, flag;
    logic [7:0]      addr = 8'h00, wd = 8'h00, rd;
    logic [3:0]      pwm;
    logic [3:0][7:0] hi;
    int              failures = 0, n_checks = 0, cyc = 0, c1;
    int              dv [8] = '{1, 2, 4, 6, 8, 12, 3, 8};
    logic [7:0]      ra [11] = '{8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hB5, 8'hBC, 8'hBD, 8'hBE, 8'hBF, 8'hCE, 8'hCF};
    logic [15:0]     wv [12] = '{16'hB500, 16'hCE00, 16'hCF09, 16'hBC00, 16'hBD03, 16'hBE80,
                                 16'hBF00, 16'hB180, 16'hB205, 16'hB380, 16'hB40A, 16'hB50B};
    fcp_pwm fcp_pwm_inst (
        .clk_i(clk_i), .nrst_i(nrst_i), .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_wdata_i(wd),
        .sfr_rdata_o(rd), .sfr_hit_o(hit), .t0_overflow_i(t0o), .timer0_ext_input_i(t0p),
        .irq_flag_clr_i(clr), .modulator_irq_flag_o(flag), .pwm_o(pwm)
    );
    fcp_load_model fcp_load_model_inst (.clk_i(clk_i), .pin_i(pwm), .clr_i(lc), .high_o(hi));
    // Clock and cycle count
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i) cyc <= cyc + 1;
    // Timer 0 overflow every 3 cycles, pin falls every 8, hang guard
    always @(posedge clk_i) begin
        #1;
        t0o = (cyc % 3 == 0);
        t0p = cyc[2];
        if (cyc == 5000) begin
            failures++;
            results();
        end
    end
    task automatic results();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        {addr, wd, wr} = {a, d, 1'b1};
        @(posedge clk_i);
        #1;
        wr = 1'b0;
        // Let an edge pass so a following write raises the strobe anew
        @(posedge clk_i);
        #1;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        addr = a;
        @(posedge clk_i);
        #1;
        cmp(rd, e);
    endtask
    // Clear a stale flag, holding clear until it reads low
    task automatic fflush();
        if (flag) begin
            clr = 1'b1;
            while (flag !== 1'b0) begin
                @(posedge clk_i);
                #1;
            end
            clr = 1'b0;
        end
    endtask
    // Wait for the flag, clear it and see it drop
    task automatic fwait();
        while (flag !== 1'b1) begin
            @(posedge clk_i);
            #1;
        end
        clr = 1'b1;
        @(posedge clk_i);
        #1;
        clr = 1'b0;
        cmp({7'h00, flag}, 8'h00);
    endtask
    // Reset values and an unused address
    task automatic t_reset();
        foreach (ra[i]) rchk(ra[i], i == 10 ? 8'hFF : 8'h00);
        rchk(8'hB6, 8'h00);
        cmp({7'h00, hit}, 8'h00);
    endtask
    // Reserved bits read zero, unmapped writes ignored
    task automatic t_regs();
        wreg(8'hB5, 8'hFF);
        rchk(8'hB5, 8'hEF);
        wreg(8'hB3, 8'hFF);
        rchk(8'hB3, 8'h83);
        wreg(8'hCE, 8'hFF);
        rchk(8'hCE, 8'h03);
        wreg(8'hB6, 8'h5A);
        rchk(8'hB6, 8'h00);
    endtask
    // Ten-cycle period: duty 3, zero duty idle high, disabled, duty past maximum
    task automatic t_wave();
        foreach (wv[i]) wreg(wv[i][15:8], wv[i][7:0]);
        repeat (12) @(posedge clk_i);
        #1;
        lc = 1'b1;
        @(posedge clk_i);
        #1;
        lc = 1'b0;
        repeat (100) @(posedge clk_i);
        #1;
        cmp(hi[0], 8'd30);
        cmp(hi[1], 8'd100);
        cmp(hi[2], 8'd100);
        cmp(hi[3], 8'd0);
    endtask
    // Period length for every count clock source
    task automatic t_sel();
        wreg(8'hCF, 8'h03);
        for (int s = 0; s < 8; s++) begin
            wreg(8'hB5, {s[2:0], 5'h01});
            fflush();
            repeat (2) fwait();
            c1 = cyc;
            fwait();
            cmp(8'(cyc - c1), 8'(4 * dv[s]));
        end
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        #1;
        nrst_i = 1'b1;
        t_reset();
        t_regs();
        t_wave();
        t_sel();
        results();
    end
endmodule
